// file: src/parallel_io_pkg.sv
/*
 * package for the parallel port block: register offsets, reset values, widths.
 * assumes a byte-wide register port with addresses decoded as printed.
 */
package parallel_io_pkg;
    localparam int          ADDR_W           = 14;
    localparam logic [13:0] FIRST_DATA_OFF   = 14'h0000;
    localparam logic [13:0] SECOND_DATA_OFF  = 14'h0001;
    localparam logic [13:0] THIRD_DATA_OFF   = 14'h0002;
    localparam logic [13:0] FOURTH_DATA_OFF  = 14'h0003;
    localparam logic [13:0] FIRST_DIR_OFF    = 14'h0004;
    localparam logic [13:0] SECOND_DIR_OFF   = 14'h0005;
    localparam logic [13:0] THIRD_DIR_OFF    = 14'h0006;
    localparam logic [13:0] FOURTH_DIR_OFF   = 14'h0007;
    localparam logic [13:0] INT_STATUS_OFF   = 14'h0008;
    localparam logic [13:0] INT_MASK_OFF     = 14'h0009;
    localparam logic [13:0] INT_SENSE_OFF    = 14'h000A;
    localparam logic [13:0] MASK_OPTION_OFF  = 14'h3FF0;
    localparam logic [7:0]  DIR_RESET        = 8'h00;
    localparam logic [7:0]  MASK_RESET       = 8'h00;
    localparam logic [7:0]  OPTION_RESET     = 8'h00;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [7:0]  SENSE_RESET      = 8'h00;
    localparam logic [7:0]  LATCH_INIT       = 8'h00;
    localparam logic [7:0]  READ_IDLE        = 8'h00;
endpackage

// file: src/parallel_io_ports.sv
/*
 * four general purpose parallel ports: three of eight bits and one of seven,
 * per-bit direction, data latches, second-port pin interrupts with pull-ups,
 * fourth port shared with the serial blocks.
 * assumes pins arrive asynchronously, a byte register port on ref_clk, and
 * serial blocks that present their own drive enables and data.
 *
 */
`timescale 1ns/1ps
module parallel_io_ports
    import parallel_io_pkg::*;
#(
    parameter int PORT_W   = 8,
    parameter int FOURTH_W = 7
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic [ADDR_W-1:0]   regAddr,
    input  wire logic [7:0]          regWrData,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic [7:0]               regRdData,
    input  wire logic                bidirectional_compat_config,
    input  wire logic                edgeAndLevel,
    input  wire logic [PORT_W-1:0]   firstPinIn,
    output logic [PORT_W-1:0]        firstPinOut,
    output logic [PORT_W-1:0]        firstPinOe,
    input  wire logic [PORT_W-1:0]   secondPinIn,
    output logic [PORT_W-1:0]        secondPinOut,
    output logic [PORT_W-1:0]        secondPinOe,
    output logic [PORT_W-1:0]        secondPullUp,
    input  wire logic [PORT_W-1:0]   thirdPinIn,
    output logic [PORT_W-1:0]        thirdPinOut,
    output logic [PORT_W-1:0]        thirdPinOe,
    input  wire logic [FOURTH_W-1:0] fourthPinIn,
    output logic [FOURTH_W-1:0]      fourthPinOut,
    output logic [FOURTH_W-1:0]      fourthPinOe,
    input  wire logic [3:0]          spiOe,
    input  wire logic [3:0]          spiOut,
    input  wire logic [1:0]          async_serial_blockOe,
    input  wire logic [1:0]          async_serial_blockOut,
    output logic                     portIrqReq,
    output logic                     irq
);
    // reset release through two flops
    logic [1:0] rstSync_q;
    logic       rstN;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // three-flop pin synchronisers, change accepted when stages two and three agree
    localparam int ALL_W = 3 * PORT_W + FOURTH_W;
    logic [ALL_W-1:0] pinRaw;
    logic [ALL_W-1:0] sync1_q;
    logic [ALL_W-1:0] sync2_q;
    logic [ALL_W-1:0] sync3_q;
    logic [ALL_W-1:0] pinLevel_q;
    assign pinRaw = {fourthPinIn, thirdPinIn, secondPinIn, firstPinIn};
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    // per-bit agreement filter
    genvar g;
    generate
        for (g = 0; g < ALL_W; g++) begin : gFilter
            always_ff @(posedge ref_clk or negedge rstN) begin
                if (!rstN) begin
                    pinLevel_q[g] <= 1'b0;
                end else if (sync2_q[g] == sync3_q[g]) begin
                    pinLevel_q[g] <= sync3_q[g];
                end
            end
        end
    endgenerate

    logic [PORT_W-1:0]   firstPin;
    logic [PORT_W-1:0]   secondPin;
    logic [PORT_W-1:0]   thirdPin;
    logic [FOURTH_W-1:0] fourthPin;
    assign firstPin  = pinLevel_q[PORT_W-1:0];
    assign secondPin = pinLevel_q[2*PORT_W-1:PORT_W];
    assign thirdPin  = pinLevel_q[3*PORT_W-1:2*PORT_W];
    assign fourthPin = pinLevel_q[ALL_W-1:3*PORT_W];

    logic wrFirstData;
    logic wrSecondData;
    logic wrThirdData;
    logic wrFourthData;
    assign wrFirstData  = regWrite && regAddr == FIRST_DATA_OFF;
    assign wrSecondData = regWrite && regAddr == SECOND_DATA_OFF;
    assign wrThirdData  = regWrite && regAddr == THIRD_DATA_OFF;
    assign wrFourthData = regWrite && regAddr == FOURTH_DATA_OFF;

    logic [PORT_W-1:0]   firstLatch_q   = LATCH_INIT;
    logic [PORT_W-1:0]   secondLatch_q  = LATCH_INIT;
    logic [PORT_W-1:0]   thirdLatch_q   = LATCH_INIT;
    logic [FOURTH_W-1:0] fourthLatch_q  = LATCH_INIT[FOURTH_W-1:0];
    always_ff @(posedge ref_clk) begin
        if (wrFirstData) begin
            firstLatch_q <= regWrData[PORT_W-1:0];
        end
        if (wrSecondData) begin
            secondLatch_q <= regWrData[PORT_W-1:0];
        end
        if (wrThirdData) begin
            thirdLatch_q <= regWrData[PORT_W-1:0];
        end
        if (wrFourthData) begin
            fourthLatch_q <= regWrData[FOURTH_W-1:0];
        end
    end

    logic [PORT_W-1:0]   firstDir_q;
    logic [PORT_W-1:0]   secondDir_q;
    logic [PORT_W-1:0]   thirdDir_q;
    logic [FOURTH_W-1:0] fourthDir_q;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            firstDir_q  <= DIR_RESET;
            secondDir_q <= DIR_RESET;
            thirdDir_q  <= DIR_RESET;
            fourthDir_q <= DIR_RESET[FOURTH_W-1:0];
        end else if (regWrite) begin
            if (regAddr == FIRST_DIR_OFF) begin
                firstDir_q <= regWrData[PORT_W-1:0];
            end
            if (regAddr == SECOND_DIR_OFF) begin
                secondDir_q <= regWrData[PORT_W-1:0];
            end
            if (regAddr == THIRD_DIR_OFF) begin
                thirdDir_q <= regWrData[PORT_W-1:0];
            end
            if (regAddr == FOURTH_DIR_OFF) begin
                fourthDir_q <= regWrData[FOURTH_W-1:0];
            end
        end
    end

    // option register, one write after reset then frozen
    logic [PORT_W-1:0] option_q;
    logic              optionDone_q;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            option_q     <= OPTION_RESET;
            optionDone_q <= 1'b0;
        end else if (regWrite && regAddr == MASK_OPTION_OFF && !optionDone_q) begin
            option_q     <= regWrData[PORT_W-1:0];
            optionDone_q <= 1'b1;
        end
    end

    // pins driven from latch where direction is one
    assign firstPinOut  = firstLatch_q;
    assign firstPinOe   = firstDir_q;
    assign secondPinOut = secondLatch_q;
    assign secondPinOe  = secondDir_q;
    assign thirdPinOut  = thirdLatch_q;
    assign thirdPinOe   = thirdDir_q;

    // pull-up when option on and pin is input
    assign secondPullUp = option_q & ~secondDir_q;

    // fourth port drive only in bidirectional config
    // serial blocks own their shared pins while driving
    logic [FOURTH_W-1:0] serialOe;
    logic [FOURTH_W-1:0] serialOut;
    logic [FOURTH_W-1:0] portOe;
    assign serialOe  = {1'b0, spiOe, async_serial_blockOe};
    assign serialOut = {1'b0, spiOut, async_serial_blockOut};
    assign portOe    = bidirectional_compat_config ? fourthDir_q : '0;
    always_comb begin
        for (int i = 0; i < FOURTH_W; i++) begin
            // serial drivers held off during reset
            fourthPinOe[i]  = rstN && serialOe[i] ? 1'b1 : portOe[i];
            fourthPinOut[i] = rstN && serialOe[i] ? serialOut[i] : fourthLatch_q[i];
        end
    end

    // second-port interrupt: falling edge, or low level in edge-and-level mode
    logic [PORT_W-1:0] secondPrev_q;
    logic [PORT_W-1:0] intEvent;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            secondPrev_q <= {PORT_W{1'b1}};
        end else begin
            secondPrev_q <= secondPin;
        end
    end
    assign intEvent = option_q & ~secondDir_q & ~secondPin &
                      (secondPrev_q | {PORT_W{edgeAndLevel}});
    assign portIrqReq = |intEvent;

    // sticky status, write one to clear, set wins
    logic [PORT_W-1:0] status_q;
    logic [PORT_W-1:0] mask_q;
    logic [PORT_W-1:0] clearBits;
    assign clearBits = (regWrite && regAddr == INT_STATUS_OFF) ? regWrData[PORT_W-1:0] : '0;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= (status_q & ~clearBits) | intEvent;
        end
    end
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            mask_q <= MASK_RESET;
        end else if (regWrite && regAddr == INT_MASK_OFF) begin
            mask_q <= regWrData[PORT_W-1:0];
        end
    end
    assign irq = |(status_q & mask_q);

    // read mux: pin for inputs, latch for outputs
    logic [7:0] rdMux;
    always_comb begin
        case (regAddr)
            FIRST_DATA_OFF:  rdMux = (firstLatch_q & firstDir_q) | (firstPin & ~firstDir_q);
            SECOND_DATA_OFF: rdMux = (secondLatch_q & secondDir_q) | (secondPin & ~secondDir_q);
            THIRD_DATA_OFF:  rdMux = (thirdLatch_q & thirdDir_q) | (thirdPin & ~thirdDir_q);
            FOURTH_DATA_OFF: rdMux = {1'b0, (fourthLatch_q & portOe) | (fourthPin & ~portOe)};
            FIRST_DIR_OFF:   rdMux = firstDir_q;
            SECOND_DIR_OFF:  rdMux = secondDir_q;
            THIRD_DIR_OFF:   rdMux = thirdDir_q;
            FOURTH_DIR_OFF:  rdMux = {1'b0, fourthDir_q};
            INT_STATUS_OFF:  rdMux = status_q;
            INT_MASK_OFF:    rdMux = mask_q;
            MASK_OPTION_OFF: rdMux = option_q;
            default:         rdMux = READ_IDLE;
        endcase
    end
    // read data stands one cycle after the strobe only
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            regRdData <= READ_IDLE;
        end else begin
            regRdData <= regRead ? rdMux : READ_IDLE;
        end
    end
endmodule // parallel_io_ports

// file: testbench/io_ports_properties.sv
/* checker: assertions on the parallel port block's pins and register port.
   assumes it is bound onto parallel_io_ports with its default widths. */
`timescale 1ns/1ps
module io_ports_properties
    import parallel_io_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0]        regWrData,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [7:0]        regRdData,
    input wire logic              bidirectional_compat_config,
    input wire logic [7:0]        firstPinOut,
    input wire logic [7:0]        firstPinOe,
    input wire logic [7:0]        secondPinOe,
    input wire logic [7:0]        secondPullUp,
    input wire logic [7:0]        thirdPinOe,
    input wire logic [6:0]        fourthPinOut,
    input wire logic [6:0]        fourthPinOe,
    input wire logic [3:0]        spiOe,
    input wire logic [3:0]        spiOut,
    input wire logic              irq
);
    // one clock domain, disabled on the raw reset_n input, not on the block's synchronised reset release
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    drivers_off_a: assert property (disable iff (1'b0) !reset_n |=>
        (firstPinOe | secondPinOe | thirdPinOe | fourthPinOe) == 8'h00) else $error("pin driven in reset");
    idle_read_a: assert property (!regRead |=> regRdData == 8'h00) else $error("read data not idle");
    first_dir_a: assert property (regWrite && regAddr == FIRST_DIR_OFF |=>
        firstPinOe == $past(regWrData)) else $error("first direction wrong");
    second_dir_a: assert property (regWrite && regAddr == SECOND_DIR_OFF |=>
        secondPinOe == $past(regWrData)) else $error("second direction wrong");
    third_dir_a: assert property (regWrite && regAddr == THIRD_DIR_OFF |=>
        thirdPinOe == $past(regWrData)) else $error("third direction wrong");
    latch_drive_a: assert property (regWrite && regAddr == FIRST_DATA_OFF |=>
        firstPinOut == $past(regWrData)) else $error("latch not on pins");
    input_only_a: assert property (!bidirectional_compat_config [*2] |-> !fourthPinOe[6])
        else $error("input-only pin driven");
    spi_share_a: assert property (bidirectional_compat_config && spiOe == 4'hF |->
        fourthPinOe[5:2] == 4'hF && fourthPinOut[5:2] == spiOut) else $error("serial drive lost");
    pullup_input_a: assert property ((secondPullUp & secondPinOe) == 8'h00)
        else $error("pull-up on output");
    mask_off_a: assert property (regWrite && regAddr == INT_MASK_OFF && regWrData == 8'h00 |->
        ##2 !irq) else $error("masked irq high");
endmodule // io_ports_properties

bind parallel_io_ports io_ports_properties i_props (.*);

// file: testbench/board_pins.sv
/* board model: drives the pin inputs of all four ports.
   assumes pins packed as four bytes, the fourth port in the low seven bits. */
`timescale 1ns/1ps
module board_pins (
    input  wire logic [3:0][7:0] pinOe,
    input  wire logic [3:0][7:0] pinOut,
    input  wire logic [7:0]      pullUp,
    input  wire logic [3:0][7:0] ext,
    input  wire logic [7:0]      drv,
    output logic      [3:0][7:0] pinIn
);
    // device drive wins, released second-port pins float to pull-up or drift
    always_comb begin
        pinIn = (pinOe & pinOut) | (~pinOe & ext);
        pinIn[1] = (pinOe[1] & pinOut[1]) | (~pinOe[1] & ((drv & ext[1]) | (~drv & (pullUp | ~ext[1]))));
    end
endmodule // board_pins

// file: testbench/tb_top.sv
/* testbench: register port, pins, shared serial pins and pin interrupts.
   assumes the board model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module tb_top;
    import parallel_io_pkg::*;
    `define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
        $display("ERROR %s expected %h seen %h", nm, e, s); end end
    typedef struct packed { logic [1:0] p; logic [7:0] d, r, e, x; } row_type;
    logic            ref_clk   = 1'b0;
    logic            reset_n   = 1'b0;
    logic [13:0]     regAddr   = 14'h0000;
    logic [7:0]      regWrData = 8'h00;
    logic            regWrite  = 1'b0;
    logic            regRead   = 1'b0;
    logic            bidir     = 1'b1;
    logic            edgeLvl   = 1'b0;
    logic [3:0]      spiOe     = 4'h0;
    logic [3:0]      spiOut    = 4'h0;
    logic [1:0]      serOe     = 2'h0;
    logic [1:0]      serOut    = 2'h0;
    logic [3:0][7:0] ext       = 32'h0;
    logic [7:0]      drv       = 8'hFF;
    logic [7:0]      regRdData, secondPullUp, rdVal;
    logic            portIrqReq, irq;
    wire  [3:0][7:0] pinIn, pinOut, pinOe;
    int              n_mismatch  = 0;
    int              comparisons = 0;
    // port, data, direction, board level, expected read
    row_type         rows [4] = '{'{2'd0, 8'hA5, 8'hF0, 8'h3C, 8'hAC}, '{2'd1, 8'h5A, 8'h0F, 8'hC3, 8'hCA},
                                  '{2'd2, 8'hFF, 8'h81, 8'h00, 8'h81}, '{2'd3, 8'h55, 8'h40, 8'h2A, 8'h6A}};

    always #5 ref_clk = ~ref_clk;
    assign pinOe[3][7] = 1'b0;
    assign pinOut[3][7] = 1'b0;

    parallel_io_ports i_parallel_io_ports (
        .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .bidirectional_compat_config(bidir), .edgeAndLevel(edgeLvl),
        .firstPinIn(pinIn[0]), .firstPinOut(pinOut[0]), .firstPinOe(pinOe[0]),
        .secondPinIn(pinIn[1]), .secondPinOut(pinOut[1]), .secondPinOe(pinOe[1]), .secondPullUp(secondPullUp),
        .thirdPinIn(pinIn[2]), .thirdPinOut(pinOut[2]), .thirdPinOe(pinOe[2]),
        .fourthPinIn(pinIn[3][6:0]), .fourthPinOut(pinOut[3][6:0]), .fourthPinOe(pinOe[3][6:0]),
        .spiOe(spiOe), .spiOut(spiOut), .async_serial_blockOe(serOe), .async_serial_blockOut(serOut),
        .portIrqReq(portIrqReq), .irq(irq));
    board_pins i_board_pins (.pinOe(pinOe), .pinOut(pinOut), .pullUp(secondPullUp), .ext(ext), .drv(drv),
        .pinIn(pinIn));

    // one-cycle register write, settled outputs on return
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    // one-cycle register read, data taken in the following cycle
    task automatic rd(input logic [13:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rdVal = regRdData;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        idle(5);
        `CHK("oe at reset", 32'h0, pinOe)
        @(posedge ref_clk) reset_n <= 1'b1;
        idle(3);
        foreach (rows[i]) begin
            @(posedge ref_clk) ext[rows[i].p] <= rows[i].e;
            wr(FIRST_DATA_OFF + rows[i].p, rows[i].d);
            wr(FIRST_DIR_OFF + rows[i].p, rows[i].r);
            `CHK("direction", rows[i].r, pinOe[rows[i].p])
            idle(8);
            rd(FIRST_DATA_OFF + rows[i].p);
            `CHK("port read", rows[i].x, rdVal)
        end
        $display("table done");
        @(posedge ref_clk) reset_n <= 1'b0;
        idle(2);
        `CHK("oe in reset", 32'h0, pinOe)
        @(posedge ref_clk) reset_n <= 1'b1;
        idle(3);
        wr(FIRST_DIR_OFF, 8'hFF);
        `CHK("latch kept", 8'hA5, pinOut[0])
        @(posedge ref_clk) bidir <= 1'b0;
        wr(FOURTH_DIR_OFF, 8'h7F);
        `CHK("input only", 8'h00, pinOe[3])
        @(posedge ref_clk) {bidir, spiOe, spiOut, serOe, serOut} <= {1'b1, 4'hF, 4'hA, 2'h3, 2'h1};
        wr(FOURTH_DIR_OFF, 8'h00);
        `CHK("shared oe", 8'h3F, pinOe[3])
        `CHK("shared out", 6'h29, pinOut[3][5:0])
        $display("reset and sharing done");
        @(posedge ref_clk) {spiOe, serOe, ext[1], drv} <= {4'h0, 2'h0, 8'hFF, 8'hFE};
        wr(SECOND_DATA_OFF, 8'hFF);
        wr(SECOND_DIR_OFF, 8'h00);
        wr(MASK_OPTION_OFF, 8'h01);
        wr(MASK_OPTION_OFF, 8'h00);
        `CHK("pull-up", 8'h01, secondPullUp)
        idle(8);
        rd(SECOND_DATA_OFF);
        `CHK("pulled level", 8'hFF, rdVal)
        wr(INT_MASK_OFF, 8'h01);
        wr(INT_STATUS_OFF, 8'hFF);
        `CHK("irq idle", 1'b0, irq)
        @(posedge ref_clk) {drv, ext[1]} <= {8'hFF, 8'hFE};
        idle(8);
        `CHK("irq edge", 1'b1, irq)
        rd(INT_STATUS_OFF);
        `CHK("status", 8'h01, rdVal)
        wr(INT_STATUS_OFF, 8'h01);
        idle(8);
        `CHK("edge only", 1'b0, irq)
        `CHK("no request", 1'b0, portIrqReq)
        @(posedge ref_clk) edgeLvl <= 1'b1;
        idle(8);
        `CHK("level sense", 1'b1, irq)
        `CHK("level request", 1'b1, portIrqReq)
        wr(INT_MASK_OFF, 8'h00);
        idle(2);
        `CHK("masked", 1'b0, irq)
        rd(INT_SENSE_OFF);
        `CHK("unmapped", 8'h00, rdVal)
        $display("interrupt done");
        wrap_up();
    end
endmodule // tb_top
